// file: common/caller_match_pkg.sv
// constants and types for the caller match block
// Operation
// - capture number once ring threshold is reached
// - no wildcard: equal length, equal characters
// - match while enabled sets output on
// - enable low holds output; clear forces off
// - retention keeps output across power-down
// - stored number: 28 chars from +,-*0-9
// - ring threshold 1 to 20, shared setting
// - trailing asterisk matches one or more characters
// - ignore detection 15 s after last ring
// - count modem ring notifications, not audible rings
// - never issue a call answer command
// - detect at lower of threshold and auto-answer
`default_nettype none
package caller_match_pkg;
  localparam int unsigned clk_hz = 50_000_000;
  localparam int unsigned guard_s = 15;
  localparam int unsigned num_len = 28;
  localparam int unsigned ring_min = 1;
  localparam int unsigned ring_max = 20;
  localparam logic [7:0] ch_plus = 8'h2B;
  localparam logic [7:0] ch_comma = 8'h2C;
  localparam logic [7:0] ch_minus = 8'h2D;
  localparam logic [7:0] ch_star = 8'h2A;
  localparam logic [7:0] ch_zero = 8'h30;
  localparam logic [7:0] ch_nine = 8'h39;
  // AXI4-Lite register byte offsets
  localparam logic [7:0] reg_ctrl = 8'h00;
  localparam logic [7:0] reg_status = 8'h04;
  localparam logic [7:0] reg_len = 8'h08;
  localparam logic [7:0] reg_cap_len = 8'h0C;
  localparam logic [7:0] reg_num_base = 8'h10;
  localparam logic [7:0] reg_cap_base = 8'h80;
  // control register fields
  localparam int unsigned ctrl_ring_lsb = 0;
  localparam int unsigned ctrl_aa_lsb = 8;
  localparam int unsigned ctrl_retain_bit = 16;
  localparam logic [4:0] ring_reset = 5'h01;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef enum logic [1:0] {st_idle, st_ring, st_guard} state_t;
endpackage
`default_nettype wire

// file: logic/caller_match_block.sv
// caller number detector: ring counting, number capture, match and guard time
`default_nettype none
module caller_match_block #(
  parameter int unsigned guard_cycles = caller_match_pkg::guard_s * caller_match_pkg::clk_hz,
  parameter int unsigned len_max = caller_match_pkg::num_len
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // modem notification stream (same clock, from line decoder)
  input wire logic ring_seen,
  input wire logic clip_char_valid,
  input wire logic [7:0] clip_char,
  input wire logic clip_done,
  // function pins (from outside, synchronised here)
  input wire logic match_enable,
  input wire logic clear_in,
  input wire logic power_down,
  // result
  output logic detect_out,
  output logic guard_active,
  output logic answer_cmd,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int unsigned lw = $clog2(len_max + 1);
  localparam int unsigned gw = $clog2(guard_cycles + 1);

  function automatic logic char_ok(input logic [7:0] c);
    char_ok = (c == caller_match_pkg::ch_plus) || (c == caller_match_pkg::ch_comma) ||
              (c == caller_match_pkg::ch_minus) || (c == caller_match_pkg::ch_star) ||
              ((c >= caller_match_pkg::ch_zero) && (c <= caller_match_pkg::ch_nine));
  endfunction

  function automatic logic [4:0] ring_clip(input logic [4:0] r);
    if (r < 5'(caller_match_pkg::ring_min)) ring_clip = 5'(caller_match_pkg::ring_min);
    else if (r > 5'(caller_match_pkg::ring_max)) ring_clip = 5'(caller_match_pkg::ring_max);
    else ring_clip = r;
  endfunction

  // window of len_max word registers starting at base
  function automatic logic in_win(input logic [7:0] a, input logic [7:0] base);
    in_win = (a >= base) && (a < base + 8'(4 * len_max));
  endfunction

  function automatic logic [lw-1:0] win_idx(input logic [7:0] a, input logic [7:0] base);
    win_idx = lw'((a - base) >> 2);
  endfunction

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [2:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {power_down, clear_in, match_enable};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire en_w = pin_s2_q[0];
  wire clr_w = pin_s2_q[1];
  wire pd_w = pin_s2_q[2];

  // ==========================================================
  // registers
  // ==========================================================
  logic [4:0] ring_thr_q, aa_thr_q;
  logic retain_q;
  logic [lw-1:0] num_len_q;
  logic [7:0] num_q [len_max];
  logic [7:0] cap_q [len_max];
  logic [lw-1:0] cap_len_q;
  logic cap_ovf_q;
  logic [4:0] ring_cnt_q;
  logic [gw-1:0] guard_q;
  caller_match_pkg::state_t state_q;
  logic capture_q;
  logic detect_q, held_q;

  // detection threshold: lower of own threshold and modem auto-answer count
  wire [4:0] thr_w = (aa_thr_q != 5'h00 && aa_thr_q < ring_thr_q) ? aa_thr_q : ring_thr_q;

  // ==========================================================
  // number comparison
  // ==========================================================
  wire star_end_w = (num_len_q != '0) &&
                    (num_q[num_len_q - lw'(1)] == caller_match_pkg::ch_star);
  wire [lw-1:0] pre_len_w = star_end_w ? num_len_q - lw'(1) : num_len_q;
  logic prefix_eq;
  always_comb begin
    prefix_eq = 1'b1;
    for (int i = 0; i < len_max; i++) begin
      if (lw'(i) < pre_len_w && num_q[i] != cap_q[i]) prefix_eq = 1'b0;
    end
  end
  wire len_ok_w = star_end_w ? (cap_len_q > pre_len_w) : (cap_len_q == num_len_q);
  wire match_w = prefix_eq && len_ok_w && !cap_ovf_q && (num_len_q != '0);

  // ==========================================================
  // ring counting, capture and guard
  // ==========================================================
  // any call, compared or not, times out a guard interval after its last ring
  wire guard_end_w = (state_q != caller_match_pkg::st_idle) && (guard_q == '0);
  wire eval_w = capture_q && clip_done;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= caller_match_pkg::st_idle;
      ring_cnt_q <= 5'h00;
      guard_q <= '0;
      capture_q <= 1'b0;
      cap_len_q <= '0;
      cap_ovf_q <= 1'b0;
    end else begin
      if (ring_seen) begin
        guard_q <= gw'(guard_cycles - 1);
        if (state_q != caller_match_pkg::st_guard) begin
          state_q <= caller_match_pkg::st_ring;
          if (ring_cnt_q != 5'h1F) ring_cnt_q <= ring_cnt_q + 5'h01;
          capture_q <= (ring_cnt_q + 5'h01 == thr_w);
          cap_len_q <= '0;
          cap_ovf_q <= 1'b0;
        end
      end else if (guard_end_w) begin
        state_q <= caller_match_pkg::st_idle;
        ring_cnt_q <= 5'h00;
        cap_len_q <= '0;
        capture_q <= 1'b0;
      end else begin
        if (state_q != caller_match_pkg::st_idle && guard_q != '0) guard_q <= guard_q - gw'(1);
        if (clip_char_valid && capture_q) begin
          if (cap_len_q == lw'(len_max)) cap_ovf_q <= 1'b1;
          else cap_len_q <= cap_len_q + lw'(1);
        end
        if (eval_w) begin
          capture_q <= 1'b0;
          state_q <= caller_match_pkg::st_guard;
        end
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (clip_char_valid && capture_q && !ring_seen && cap_len_q != lw'(len_max))
      cap_q[cap_len_q] <= clip_char;
  end

  // ==========================================================
  // detection output with retention
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_q <= 1'b0;
      held_q <= 1'b0;
    end else begin
      if (clr_w) detect_q <= 1'b0;
      else if (pd_w) detect_q <= retain_q ? detect_q : 1'b0;
      else if (eval_w && en_w && match_w && !ring_seen) detect_q <= 1'b1;
      if (pd_w) held_q <= retain_q && detect_q && !clr_w;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_out <= 1'b0;
      guard_active <= 1'b0;
      answer_cmd <= 1'b0;
    end else begin
      detect_out <= detect_q;
      guard_active <= (state_q == caller_match_pkg::st_guard);
      answer_cmd <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  // ==========================================================
  logic aw_got_q, w_got_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  wire do_wr_w = aw_got_q && w_got_q && !s_axi_bvalid;
  wire num_hit_w = in_win(aw_q, caller_match_pkg::reg_num_base);
  wire [lw-1:0] num_idx_w = win_idx(aw_q, caller_match_pkg::reg_num_base);
  wire wr_ctrl_w = aw_q == caller_match_pkg::reg_ctrl;
  wire wr_len_w = aw_q == caller_match_pkg::reg_len;
  wire wr_ok_w = wr_ctrl_w || wr_len_w || num_hit_w;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= caller_match_pkg::resp_okay;
      ring_thr_q <= caller_match_pkg::ring_reset;
      aa_thr_q <= 5'h00;
      retain_q <= 1'b0;
      num_len_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        w_q <= s_axi_wdata;
      end
      if (do_wr_w) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok_w ? caller_match_pkg::resp_okay : caller_match_pkg::resp_slverr;
        if (wr_ctrl_w) begin
          ring_thr_q <= ring_clip(w_q[caller_match_pkg::ctrl_ring_lsb +: 5]);
          aa_thr_q <= w_q[caller_match_pkg::ctrl_aa_lsb +: 5];
        end
        if (wr_ctrl_w) retain_q <= w_q[caller_match_pkg::ctrl_retain_bit];
        if (wr_len_w) num_len_q <= (w_q[7:0] > 8'(len_max)) ? lw'(len_max) : lw'(w_q[7:0]);
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // characters outside the allowed set are dropped, the old one stays
  always_ff @(posedge aclk) begin
    if (do_wr_w && num_hit_w && char_ok(w_q[7:0])) num_q[num_idx_w] <= w_q[7:0];
  end
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;

  wire [7:0] ra_w = s_axi_araddr;
  wire rnum_w = in_win(ra_w, caller_match_pkg::reg_num_base);
  wire rcap_w = in_win(ra_w, caller_match_pkg::reg_cap_base);
  wire [lw-1:0] rni_w = win_idx(ra_w, caller_match_pkg::reg_num_base);
  wire [lw-1:0] rci_w = win_idx(ra_w, caller_match_pkg::reg_cap_base);
  logic [31:0] rd_w;
  logic rd_ok;
  always_comb begin
    rd_w = 32'h0;
    rd_ok = 1'b1;
    if (ra_w == caller_match_pkg::reg_ctrl)
      rd_w = {15'h0, retain_q, 3'h0, aa_thr_q, 3'h0, ring_thr_q};
    else if (ra_w == caller_match_pkg::reg_status)
      rd_w = {16'h0, 3'h0, ring_cnt_q, 4'h0, held_q, capture_q,
              state_q == caller_match_pkg::st_guard, detect_q};
    else if (ra_w == caller_match_pkg::reg_len) rd_w = 32'(num_len_q);
    else if (ra_w == caller_match_pkg::reg_cap_len) rd_w = 32'(cap_len_q);
    else if (rnum_w) rd_w = {24'h0, num_q[rni_w]};
    else if (rcap_w) rd_w = {24'h0, cap_q[rci_w]};
    else rd_ok = 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= caller_match_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_w;
      s_axi_rresp <= rd_ok ? caller_match_pkg::resp_okay : caller_match_pkg::resp_slverr;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // ==========================================================
  // checks
  // ==========================================================
  sequence clr_seen;
    clr_w;
  endsequence
  chk_clear_forces_off: assert property (@(posedge aclk) disable iff (!aresetn)
    clr_seen |=> !detect_q)
    else $error("clear did not force output off");
  chk_hold_when_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (!en_w && !clr_w && !pd_w) |=> $stable(detect_q))
    else $error("output changed while disabled");
  chk_match_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    (eval_w && en_w && match_w && !clr_w && !pd_w && !ring_seen) |=> detect_q)
    else $error("match did not set output");
  chk_rise_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(detect_q) |-> $past(eval_w && en_w && match_w))
    else $error("output rose without match");
  chk_out_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    detect_out == $past(detect_q))
    else $error("output pin does not follow detect state");
  chk_no_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    !answer_cmd)
    else $error("answer command issued");
  chk_guard_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == caller_match_pkg::st_guard && ring_seen) |=> !capture_q)
    else $error("capture armed inside guard");
  chk_guard_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(detect_q) |-> $past(state_q) != caller_match_pkg::st_guard)
    else $error("output rose inside guard");
  chk_guard_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    ring_seen |=> guard_q == gw'(guard_cycles - 1))
    else $error("ring did not restart guard");
  chk_thr_range: assert property (@(posedge aclk) disable iff (!aresetn)
    ring_thr_q >= 5'(caller_match_pkg::ring_min) && ring_thr_q <= 5'(caller_match_pkg::ring_max))
    else $error("ring threshold out of range");
  chk_thr_select: assert property (@(posedge aclk) disable iff (!aresetn)
    (thr_w <= ring_thr_q) && (aa_thr_q == 5'h00 || thr_w <= aa_thr_q))
    else $error("detection threshold not the lower count");
  chk_guard_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (guard_end_w && !ring_seen) |=> (ring_cnt_q == 5'h00 && cap_len_q == '0))
    else $error("guard end did not clear count");
  chk_capture_arm: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(capture_q) |-> $past(ring_seen) && ring_cnt_q == thr_w)
    else $error("capture armed at wrong ring");
  sequence ring_taken;
    ring_seen && state_q != caller_match_pkg::st_guard && ring_cnt_q != 5'h1F;
  endsequence
  chk_ring_count: assert property (@(posedge aclk) disable iff (!aresetn)
    ring_taken |=> ring_cnt_q == $past(ring_cnt_q) + 5'h01)
    else $error("ring count did not advance");
  chk_exact_len: assert property (@(posedge aclk) disable iff (!aresetn)
    (match_w && !star_end_w) |-> cap_len_q == num_len_q)
    else $error("match with unequal length");
  chk_star_any: assert property (@(posedge aclk) disable iff (!aresetn)
    (star_end_w && num_len_q == lw'(1) && cap_len_q != '0 && !cap_ovf_q) |-> match_w)
    else $error("lone wildcard did not match");
  chk_len_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    num_len_q <= lw'(len_max))
    else $error("stored length too long");
  chk_cap_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    cap_len_q <= lw'(len_max))
    else $error("captured length too long");
  chk_retain_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (pd_w && retain_q && !clr_w) |=> $stable(detect_q))
    else $error("retention lost output");
endmodule
`default_nettype wire

// file: bench/modem_model.sv
// modem model: ring and caller number notifications on the block's stream
`default_nettype none
module modem_model (
  // clock
  input wire logic aclk,
  // notification stream
  output logic ring_seen,
  output logic clip_char_valid,
  output logic [7:0] clip_char,
  output logic clip_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // auto-answer ring count, 0 when the modem never answers
  int aa_rings = 0;
  initial begin
    ring_seen = 1'b0;
    clip_char_valid = 1'b0;
    clip_char = 8'h55;
    clip_done = 1'b0;
  end
  // ==========================================
  // one incoming call
  task automatic call(input int rings, input string num);
    int n;
    // an answered call sends no more rings
    n = (aa_rings != 0 && aa_rings < rings) ? aa_rings : rings;
    for (int r = 0; r < n; r++) begin
      ring_seen <= 1'b1;
      @(posedge aclk);
      ring_seen <= 1'b0;
      for (int i = 0; i < num.len(); i++) begin
        clip_char_valid <= 1'b1;
        clip_char <= num[i];
        @(posedge aclk);
      end
      clip_char_valid <= 1'b0;
      // released character lines do not keep the last value
      clip_char <= ~clip_char;
      clip_done <= 1'b1;
      @(posedge aclk);
      clip_done <= 1'b0;
      repeat (8) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

// file: bench/caller_match_block_tb_top.sv
// testbench for the caller match block
`default_nettype none
module caller_match_block_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned guard = 200;
  logic aclk, aresetn, match_enable, clear_in, power_down, answered;
  logic ring_seen, clip_char_valid, clip_done, detect_out, guard_active, answer_cmd;
  logic [7:0] clip_char, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  typedef struct {string st; string cl; int rings; logic en; logic exp;} case_t;
  case_t cs[12] = '{
    '{"1234", "1234", 3, 1, 1}, '{"1234", "1235", 3, 1, 0}, '{"1234", "123", 3, 1, 0},
    '{"1234", "12345", 3, 1, 0}, '{"1234", "1234", 2, 1, 0}, '{"1234", "1234", 3, 0, 0},
    '{"123*", "123", 3, 1, 0}, '{"12*", "123", 3, 1, 1}, '{"12*", "12789", 3, 1, 1},
    '{"*", "555", 3, 1, 1}, '{"+*", "+4455", 3, 1, 1}, '{"+*", "4455", 3, 1, 0}};
  caller_match_block #(.guard_cycles(guard)) dut (
    .aclk, .aresetn, .ring_seen, .clip_char_valid, .clip_char, .clip_done, .match_enable,
    .clear_in, .power_down, .detect_out, .guard_active, .answer_cmd, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  modem_model modem (.aclk, .ring_seen, .clip_char_valid, .clip_char, .clip_done);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (answer_cmd !== 1'b0 && aresetn === 1'b1) answered <= 1'b1;
    if (cyc == 30000) begin
      error_cnt++;
      summarize();
    end
  end
  // ==========================================
  // checking and bus tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 200);
    s_axi_bready <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge aclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 200);
    s_axi_rready <= 1'b0;
    chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
    chk("rdata", exp, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge aclk);
  endtask
  task automatic set_num(input string s);
    for (int i = 0; i < s.len(); i++) begin
      wr(caller_match_pkg::reg_num_base + 8'(4 * i), {24'h0, s[i]}, 2'h0);
    end
    wr(caller_match_pkg::reg_len, 32'(s.len()), 2'h0);
  endtask
  task automatic pulse(input logic pd, input logic exp);
    if (pd) power_down <= 1'b1;
    else clear_in <= 1'b1;
    cycles(5);
    power_down <= 1'b0;
    clear_in <= 1'b0;
    cycles(5);
    chk("detect_out", {31'h0, exp}, {31'h0, detect_out});
  endtask
  task automatic call_chk(input int rings, input string num, input logic en, input logic exp);
    match_enable <= en;
    cycles(4);
    modem.call(rings, num);
    cycles(4);
    chk("detect_out", {31'h0, exp}, {31'h0, detect_out});
  endtask
  task automatic run(input int rings, input string num, input logic en, input logic exp);
    call_chk(rings, num, en, exp);
    cycles(guard + 20);
    pulse(1'b0, 1'b0);
  endtask
  // ==========================================
  // test sequence
  initial begin
    {aresetn, match_enable, clear_in, power_down, answered} = 5'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    cycles(20);
    aresetn <= 1'b1;
    cycles(1);
    rd_chk(caller_match_pkg::reg_ctrl, 32'h1, 2'h0);
    rd_chk(caller_match_pkg::reg_status, 32'h0, 2'h0);
    rd_chk(8'hF0, 32'h0, 2'h2);
    wr(8'hF0, 32'h7, 2'h2);
    wr(caller_match_pkg::reg_ctrl, 32'h15, 2'h0);
    rd_chk(caller_match_pkg::reg_ctrl, 32'h14, 2'h0);
    wr(caller_match_pkg::reg_ctrl, 32'h0, 2'h0);
    rd_chk(caller_match_pkg::reg_ctrl, 32'h1, 2'h0);
    wr(caller_match_pkg::reg_ctrl, 32'h0001_0502, 2'h0);
    rd_chk(caller_match_pkg::reg_ctrl, 32'h0001_0502, 2'h0);
    set_num("+49,2102-1234567890123456789");
    rd_chk(caller_match_pkg::reg_len, 32'h1C, 2'h0);
    wr(caller_match_pkg::reg_len, 32'h1E, 2'h0);
    rd_chk(caller_match_pkg::reg_len, 32'h1C, 2'h0);
    wr(caller_match_pkg::reg_num_base, 32'h41, 2'h0);
    rd_chk(caller_match_pkg::reg_num_base, 32'h2B, 2'h0);
    wr(caller_match_pkg::reg_ctrl, 32'h1, 2'h0);
    run(1, "+49,2102-1234567890123456789", 1'b1, 1'b1);
    $display("test registers and long number done");
    wr(caller_match_pkg::reg_ctrl, 32'h3, 2'h0);
    foreach (cs[k]) begin
      set_num(cs[k].st);
      run(cs[k].rings, cs[k].cl, cs[k].en, cs[k].exp);
    end
    $display("test match table done");
    set_num("1234");
    call_chk(3, "1234", 1'b1, 1'b1);
    chk("guard_active", 32'h1, {31'h0, guard_active});
    rd_chk(caller_match_pkg::reg_cap_len, 32'h4, 2'h0);
    rd_chk(caller_match_pkg::reg_cap_base + 8'h04, 32'h32, 2'h0);
    pulse(1'b0, 1'b0);
    call_chk(3, "1234", 1'b1, 1'b0);
    cycles(guard + 20);
    rd_chk(caller_match_pkg::reg_status, 32'h0, 2'h0);
    run(3, "1234", 1'b1, 1'b1);
    call_chk(2, "1234", 1'b1, 1'b0);
    cycles(guard + 20);
    rd_chk(caller_match_pkg::reg_status, 32'h0, 2'h0);
    $display("test guard time done");
    wr(caller_match_pkg::reg_ctrl, 32'h0001_0003, 2'h0);
    call_chk(3, "1234", 1'b1, 1'b1);
    cycles(guard + 20);
    call_chk(3, "9999", 1'b0, 1'b1);
    pulse(1'b1, 1'b1);
    wr(caller_match_pkg::reg_ctrl, 32'h3, 2'h0);
    pulse(1'b1, 1'b0);
    cycles(guard + 20);
    $display("test hold and retention done");
    modem.aa_rings = 2;
    wr(caller_match_pkg::reg_ctrl, 32'h0000_0203, 2'h0);
    run(3, "1234", 1'b1, 1'b1);
    modem.aa_rings = 0;
    chk("answer_cmd", 32'h0, {31'h0, answered});
    $display("test auto answer done");
    summarize();
  end
endmodule
`default_nettype wire
